// ### gpa_consts.vh
// Constants for the four-bit port with wake-up
`ifndef GPA_CONSTS_VH
`define GPA_CONSTS_VH
`define GPA_SEL_DATA 2'h0
`define GPA_SEL_DIR 2'h1
`define GPA_SEL_PULL 2'h2
`define GPA_SEL_WAKE 2'h3
`define GPA_RST_DATA 4'hf
`define GPA_RST_DIR 4'hf
`define GPA_RST_PULL 4'h0
`define GPA_RST_WAKE 4'h0
`define GPA_PINS 4
`endif

// ### gpa_port.v
// Four-bit bidirectional port with pull-high and falling-edge wake-up
// Function
// - Data read of an input pin returns the live synchronised pin level.
// - Written data held in output latch until software rewrites it.
// - Direction bit 1 makes pin input; 0 drives latch as CMOS output; pins with pin_open_drain_i set drive only the low level.
// - Data read of an output pin returns the latch, not the pin.
// - Power-on or normal watchdog reset sets data and direction to ones.
// - Pull-high bit 1 enables weak pull-high; 0 disables it.
// - Pull-high only when pin is digital input or open-drain output.
// - Enabled pin falling edge wakes device from sleep or idle.
// - Wake-up enable honoured only for input pins in sleep or idle.
// - Bits 7 to 4 ignore writes and read as zero.
// - Watchdog time-out in sleep or idle leaves all port registers.
// - Each register is its own data-memory location.
// - Bit i of each register acts only on pin i.
`timescale 1ns/1ps
`include "gpa_consts.vh"
module gpa_port
(
    input wire clk_sys_i,
    input wire rst_i,
    input wire wdt_timeout_i,
    input wire low_power_i,
    input wire [1:0] reg_sel_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    input wire [3:0] pin_in_i,
    input wire [3:0] pin_func_gpio_i,
    input wire [3:0] pin_open_drain_i,
    output wire [3:0] pin_out_o,
    output wire [3:0] pin_oe_o,
    output wire [3:0] pin_pullup_o,
    output wire wakeup_o
);
    reg [3:0] port_a_data_latch;
    reg [3:0] port_a_direction;
    reg [3:0] port_a_pullup_enable;
    reg [3:0] port_a_wakeup_enable;
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;
    reg [3:0] pin_prev;
    reg [3:0] next_rdata;
    wire full_reset;
    wire wr_data;
    wire wr_dir;
    wire wr_pull;
    wire wr_wake;
    wire [3:0] fall;
    wire [3:0] wake_hit;

    // Register select decode, shared by all four write strobes
    function gpa_sel_is;
        input [1:0] sel;
        input [1:0] code;
        begin
            gpa_sel_is = (sel == code);
        end
    endfunction

    // Pin behaves as a plain port input
    function gpa_is_input;
        input func_gpio;
        input dir_bit;
        begin
            gpa_is_input = func_gpio & dir_bit;
        end
    endfunction

    // Sleep time-out only restarts the core, port keeps its state
    assign full_reset = rst_i | (wdt_timeout_i & ~low_power_i);

    assign wr_data = reg_wr_i & gpa_sel_is(reg_sel_i, `GPA_SEL_DATA);
    assign wr_dir = reg_wr_i & gpa_sel_is(reg_sel_i, `GPA_SEL_DIR);
    assign wr_pull = reg_wr_i & gpa_sel_is(reg_sel_i, `GPA_SEL_PULL);
    assign wr_wake = reg_wr_i & gpa_sel_is(reg_sel_i, `GPA_SEL_WAKE);

    // Output latch holds until software rewrites it
    always @(posedge clk_sys_i)
    begin
        if (full_reset)
        begin
            port_a_data_latch <= `GPA_RST_DATA;
        end
        else if (wr_data)
        begin
            // Upper bits dropped on write
            port_a_data_latch <= reg_wdata_i[3:0];
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (full_reset)
        begin
            port_a_direction <= `GPA_RST_DIR;
        end
        else if (wr_dir)
        begin
            port_a_direction <= reg_wdata_i[3:0];
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (full_reset)
        begin
            port_a_pullup_enable <= `GPA_RST_PULL;
        end
        else if (wr_pull)
        begin
            port_a_pullup_enable <= reg_wdata_i[3:0];
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (full_reset)
        begin
            port_a_wakeup_enable <= `GPA_RST_WAKE;
        end
        else if (wr_wake)
        begin
            port_a_wakeup_enable <= reg_wdata_i[3:0];
        end
    end

    // Pins are asynchronous; two flops before use
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pin_meta <= 4'hf;
            pin_sync <= 4'hf;
            pin_prev <= 4'hf;
        end
        else
        begin
            pin_meta <= pin_in_i;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Edge history starts high, so a pin already low at reset release shows one fall
    assign fall = pin_prev & ~pin_sync;

    genvar i;
    generate
        for (i = 0; i < `GPA_PINS; i = i + 1)
        begin : g_pin
            // Open-drain drives only low
            assign pin_oe_o[i] = ~port_a_direction[i] & pin_func_gpio_i[i]
                & ~(pin_open_drain_i[i] & port_a_data_latch[i]);
            assign pin_out_o[i] = port_a_data_latch[i];
            assign pin_pullup_o[i] = port_a_pullup_enable[i]
                & (gpa_is_input(pin_func_gpio_i[i], port_a_direction[i])
                | pin_open_drain_i[i]);
            assign wake_hit[i] = port_a_wakeup_enable[i]
                & gpa_is_input(pin_func_gpio_i[i], port_a_direction[i])
                & low_power_i & fall[i];
        end
    endgenerate

    // Any enabled pin wakes the core
    assign wakeup_o = |wake_hit;

    always @*
    begin
        next_rdata = 4'h0;
        case (reg_sel_i)
            `GPA_SEL_DATA:
            begin
                // Input pins read live, output pins read the latch
                next_rdata = (port_a_direction & pin_sync)
                    | (~port_a_direction & port_a_data_latch);
            end
            `GPA_SEL_DIR:
            begin
                next_rdata = port_a_direction;
            end
            `GPA_SEL_PULL:
            begin
                next_rdata = port_a_pullup_enable;
            end
            `GPA_SEL_WAKE:
            begin
                next_rdata = port_a_wakeup_enable;
            end
            default:
            begin
                next_rdata = 4'h0;
            end
        endcase
    end

    // Read data held until the next read
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (reg_rd_i)
        begin
            // Unused upper bits always read as zero
            reg_rdata_o <= {4'h0, next_rdata};
        end
    end
endmodule

// ### gpa_port_checker.sv
// Port checks
`timescale 1ns/1ps
module gpa_port_checker(input wire clk_sys_i,rst_i,wdt_timeout_i,low_power_i,reg_wr_i,
input wire wakeup_o,input wire [7:0] reg_rdata_o,
input wire [3:0] pin_func_gpio_i,pin_open_drain_i,pin_out_o,pin_oe_o,pin_pullup_o);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
property p_wdt; wdt_timeout_i&&!low_power_i |=> pin_out_o==4'hf; endproperty
a_wdt: assert property (p_wdt) else $error("wdt");
property p_keep; wdt_timeout_i&&low_power_i&&!reg_wr_i |=> $stable(pin_out_o); endproperty
a_keep: assert property (p_keep) else $error("keep");
property p_pu; (pin_pullup_o&~(pin_func_gpio_i&~pin_oe_o|pin_open_drain_i))==4'h0; endproperty
a_pu: assert property (p_pu) else $error("pull");
property p_wake; wakeup_o |-> low_power_i; endproperty
a_wake: assert property (p_wake) else $error("wake outside low power");
property p_hi; reg_rdata_o[7:4]==4'h0; endproperty
a_hi: assert property (p_hi) else $error("upper read bits");
property p_wrst; wdt_timeout_i&&!low_power_i |=> pin_oe_o==4'h0&&pin_pullup_o==4'h0; endproperty
a_wrst: assert property (p_wrst) else $error("wdt pull");
endmodule

// ### gpa_pins.sv
// Switches on the port pins
`timescale 1ns/1ps
module gpa_pins(input wire [3:0] pin_out_o,pin_oe_o,sw,output wire [3:0] pin_in_i);
assign pin_in_i=pin_oe_o&pin_out_o|~pin_oe_o&sw;
endmodule

// ### gpa_port_tb_top.sv
// Port bench
`timescale 1ns/1ps
module gpa_port_tb_top;
reg clk_sys_i=0,rst_i=1,wdt_timeout_i=0,low_power_i=0,reg_wr_i=0,reg_rd_i=0;
reg [1:0] reg_sel_i=0;
reg [7:0] reg_wdata_i=0;
reg [3:0] pin_func_gpio_i=4'hf,pin_open_drain_i=0,sw=4'hf;
wire [7:0] reg_rdata_o;
wire [3:0] pin_in_i,pin_out_o,pin_oe_o,pin_pullup_o;
wire wakeup_o;
integer error_cnt=0,n_tests=0,i;
always #2 clk_sys_i=~clk_sys_i;
gpa_port gpa_port_inst(.*);
gpa_pins gpa_pins_inst(.*);
task t(input integer n); repeat(n) @(posedge clk_sys_i); #1; endtask
task chk(input [7:0] g,e);
n_tests++;
if(g!==e) begin error_cnt++; $display("BAD %0t %h %h",$time,g,e); end
endtask
task wr(input [1:0] s,input [7:0] d); reg_sel_i=s; reg_wdata_i=d; reg_wr_i=1; t(1); reg_wr_i=0; endtask
task rd(input [1:0] s,input [7:0] e); reg_sel_i=s; reg_rd_i=1; t(1); reg_rd_i=0; chk(reg_rdata_o,e); endtask
task results;
$display("errors %0d checks %0d",error_cnt,n_tests);
if(error_cnt==0&&n_tests>0) $display("All checks passed");
else $display("Checks failed");
$finish;
endtask
initial begin
t(10); rst_i=0;
for(i=0;i<4;i=i+1) rd(i,i<2?8'h0f:8'h00);
wr(1,8'hf0); chk(pin_oe_o,4'hf);
rd(1,8'h00);
pin_open_drain_i=4'hf; wr(0,8'ha5); chk(pin_out_o,4'h5);
sw=0; t(3); rd(0,8'h05);
pin_open_drain_i=0; wr(1,8'h0f); sw=7; t(3); rd(0,8'h07);
wr(2,8'h03); chk(pin_pullup_o,4'h3);
wr(3,8'h01); low_power_i=1; sw=6;
repeat(9) if(wakeup_o!==1'b1) t(1);
chk(wakeup_o,1);
wdt_timeout_i=1; t(1); wdt_timeout_i=0; rd(3,8'h01);
low_power_i=0; wdt_timeout_i=1; t(1); wdt_timeout_i=0; rd(2,8'h00);
rd(1,8'h0f);
results;
end
endmodule
bind gpa_port gpa_port_checker gpa_port_checker_inst(.*);
